//--- core/mmpp_pkg.sv
`default_nettype none
package mmpp_pkg;
  // port base byte addresses
  localparam logic [31:0] MMPP_LAMP_BASE = 32'hff200000;
  localparam logic [31:0] MMPP_DIG_LOW_BASE = 32'hff200020;
  localparam logic [31:0] MMPP_DIG_HIGH_BASE = 32'hff200030;
  localparam logic [31:0] MMPP_LEVER_BASE = 32'hff200040;
  localparam logic [31:0] MMPP_BUTTON_BASE = 32'hff200050;
  localparam logic [31:0] MMPP_HDR_BASE = 32'hff200060;
  localparam logic [31:0] MMPP_SHIELD_BASE = 32'hff200100;
  localparam logic [31:0] MMPP_SHRST_BASE = 32'hff200110;
  // word offsets inside one port
  localparam logic [31:0] MMPP_DATA_OFS = 32'h0;
  localparam logic [31:0] MMPP_DIR_OFS = 32'h4;
  localparam logic [31:0] MMPP_MASK_OFS = 32'h8;
  localparam logic [31:0] MMPP_EDGE_OFS = 32'hc;
  // implemented widths
  localparam int MMPP_WORD_W = 32;
  localparam int MMPP_LAMP_W = 10;
  localparam int MMPP_LEVER_W = 10;
  localparam int MMPP_BUTTON_W = 2;
  localparam int MMPP_PORT_W = 32;
  localparam int MMPP_SEG_W = 8;
  // reset values
  localparam logic [31:0] MMPP_DATA_RST = 32'h0;
  localparam logic [31:0] MMPP_DIR_RST = 32'h0;
  localparam logic MMPP_SHRST_RST = 1'h0;
  localparam logic [31:0] MMPP_UNMAPPED_RD = 32'h0;
endpackage : mmpp_pkg
`default_nettype wire

//--- core/mmpp_ports.sv
`timescale 1ns/1ps
`default_nettype none
module mmpp_ports
  import mmpp_pkg::*;
#(
  parameter int HDR_W = MMPP_PORT_W,
  parameter int SHIELD_W = MMPP_PORT_W
)
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic [MMPP_LAMP_W-1:0] red_lamp_outputs_o,
  output logic [MMPP_SEG_W-1:0] digit_zero_o,
  output logic [MMPP_SEG_W-1:0] digit_one_o,
  output logic [MMPP_SEG_W-1:0] digit_two_o,
  output logic [MMPP_SEG_W-1:0] digit_three_o,
  output logic [MMPP_SEG_W-1:0] digit_four_o,
  output logic [MMPP_SEG_W-1:0] digit_five_o,
  input wire logic [MMPP_LEVER_W-1:0] slider_levers_i,
  input wire logic [MMPP_BUTTON_W-1:0] pushbutton_inputs_i,
  input wire logic [HDR_W-1:0] header_data_bits_i,
  output logic [HDR_W-1:0] header_data_bits_o,
  output logic [HDR_W-1:0] header_data_bits_oe_b_o,
  input wire logic [SHIELD_W-1:0] shield_user_signal_i,
  output logic [SHIELD_W-1:0] shield_user_signal_o,
  output logic [SHIELD_W-1:0] shield_user_signal_oe_b_o,
  output logic shield_reset_b_o
);

  localparam int IN_W = MMPP_LEVER_W + MMPP_BUTTON_W + HDR_W + SHIELD_W;

  if (HDR_W < 1 || HDR_W > MMPP_WORD_W || SHIELD_W < 1 || SHIELD_W > MMPP_WORD_W)
  begin : g_bad_width
    $error("port widths must lie between 1 and 32");
  end

  // bits 1:0 are dropped, so any byte address inside a word aliases to that word
  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a[31:2] == b[31:2]);
  endfunction : hit

  // three-stage pin synchroniser; a bit moves once stages two and three agree
  // costs two extra cycles of latency, but a one-cycle glitch never reaches a read
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  logic [IN_W-1:0] sync3;
  logic [IN_W-1:0] filt;
  logic [IN_W-1:0] next_filt;

  assign raw_in = {shield_user_signal_i, header_data_bits_i, pushbutton_inputs_i,
                   slider_levers_i};

  always_comb
  begin
    next_filt = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  logic [MMPP_LEVER_W-1:0] lever_lvl;
  logic [MMPP_BUTTON_W-1:0] button_lvl;
  logic [HDR_W-1:0] hdr_pin;
  logic [SHIELD_W-1:0] shd_pin;

  assign lever_lvl = filt[MMPP_LEVER_W-1:0];
  assign button_lvl = filt[MMPP_LEVER_W +: MMPP_BUTTON_W];
  assign hdr_pin = filt[MMPP_LEVER_W + MMPP_BUTTON_W +: HDR_W];
  assign shd_pin = filt[MMPP_LEVER_W + MMPP_BUTTON_W + HDR_W +: SHIELD_W];

  // register file
  logic [MMPP_LAMP_W-1:0] lamp;
  logic [31:0] dig_low;
  logic [31:0] dig_high;
  logic [HDR_W-1:0] hdr_data;
  logic [HDR_W-1:0] hdr_dir;
  logic [HDR_W-1:0] hdr_oe_b;
  logic [SHIELD_W-1:0] shd_data;
  logic [SHIELD_W-1:0] shd_dir;
  logic [SHIELD_W-1:0] shd_oe_b;
  logic shd_rst;
  logic [31:0] rdata;
  logic rvalid;

  logic [MMPP_LAMP_W-1:0] next_lamp;
  logic [31:0] next_dig_low;
  logic [31:0] next_dig_high;
  logic [HDR_W-1:0] next_hdr_data;
  logic [HDR_W-1:0] next_hdr_dir;
  logic [SHIELD_W-1:0] next_shd_data;
  logic [SHIELD_W-1:0] next_shd_dir;
  logic next_shd_rst;
  logic [31:0] next_rdata;
  logic next_rvalid;

  // input bits show the pin, output bits show what is driven
  logic [HDR_W-1:0] hdr_view;
  logic [SHIELD_W-1:0] shd_view;

  assign hdr_view = (hdr_dir & hdr_data) | (~hdr_dir & hdr_pin);
  assign shd_view = (shd_dir & shd_data) | (~shd_dir & shd_pin);

  always_comb
  begin
    next_lamp = lamp;
    next_dig_low = dig_low;
    next_dig_high = dig_high;
    next_hdr_data = hdr_data;
    next_hdr_dir = hdr_dir;
    next_shd_data = shd_data;
    next_shd_dir = shd_dir;
    next_shd_rst = shd_rst;
    next_rvalid = rd_i;
    next_rdata = MMPP_UNMAPPED_RD;
    // writes; read-only, +8 and +c words silently drop writes
    // wdata bits above the lamp, header, shield or shield-reset width are cut off here; both digit words store all 32
    if (wr_i)
    begin
      if (hit(addr_i, MMPP_LAMP_BASE))
        next_lamp = wdata_i[MMPP_LAMP_W-1:0];
      else if (hit(addr_i, MMPP_DIG_LOW_BASE))
        next_dig_low = wdata_i;
      else if (hit(addr_i, MMPP_DIG_HIGH_BASE))
        next_dig_high = wdata_i;
      else if (hit(addr_i, MMPP_HDR_BASE + MMPP_DATA_OFS))
        next_hdr_data = wdata_i[HDR_W-1:0];
      else if (hit(addr_i, MMPP_HDR_BASE + MMPP_DIR_OFS))
        next_hdr_dir = wdata_i[HDR_W-1:0];
      else if (hit(addr_i, MMPP_SHIELD_BASE + MMPP_DATA_OFS))
        next_shd_data = wdata_i[SHIELD_W-1:0];
      else if (hit(addr_i, MMPP_SHIELD_BASE + MMPP_DIR_OFS))
        next_shd_dir = wdata_i[SHIELD_W-1:0];
      else if (hit(addr_i, MMPP_SHRST_BASE))
        next_shd_rst = wdata_i[0];
    end
    // reads; the +8/+c words of button, header and shield answer zero
    // a read beside a write in one cycle sees the old stored value
    if (rd_i)
    begin
      if (hit(addr_i, MMPP_LAMP_BASE))
        next_rdata = 32'(lamp);
      else if (hit(addr_i, MMPP_DIG_LOW_BASE))
        next_rdata = dig_low;
      else if (hit(addr_i, MMPP_DIG_HIGH_BASE))
        next_rdata = dig_high;
      else if (hit(addr_i, MMPP_LEVER_BASE))
        next_rdata = 32'(lever_lvl);
      else if (hit(addr_i, MMPP_BUTTON_BASE))
        next_rdata = 32'(button_lvl);
      else if (hit(addr_i, MMPP_HDR_BASE + MMPP_DATA_OFS))
        next_rdata = 32'(hdr_view);
      else if (hit(addr_i, MMPP_HDR_BASE + MMPP_DIR_OFS))
        next_rdata = 32'(hdr_dir);
      else if (hit(addr_i, MMPP_SHIELD_BASE + MMPP_DATA_OFS))
        next_rdata = 32'(shd_view);
      else if (hit(addr_i, MMPP_SHIELD_BASE + MMPP_DIR_OFS))
        next_rdata = 32'(shd_dir);
      else if (hit(addr_i, MMPP_SHRST_BASE))
        next_rdata = 32'(shd_rst);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lamp <= MMPP_DATA_RST[MMPP_LAMP_W-1:0];
      dig_low <= MMPP_DATA_RST;
      dig_high <= MMPP_DATA_RST;
      hdr_data <= MMPP_DATA_RST[HDR_W-1:0];
      hdr_dir <= MMPP_DIR_RST[HDR_W-1:0];
      hdr_oe_b <= ~MMPP_DIR_RST[HDR_W-1:0];
      shd_data <= MMPP_DATA_RST[SHIELD_W-1:0];
      shd_dir <= MMPP_DIR_RST[SHIELD_W-1:0];
      shd_oe_b <= ~MMPP_DIR_RST[SHIELD_W-1:0];
      shd_rst <= MMPP_SHRST_RST;
      rdata <= MMPP_UNMAPPED_RD;
      rvalid <= 1'h0;
    end
    else
    begin
      lamp <= next_lamp;
      dig_low <= next_dig_low;
      dig_high <= next_dig_high;
      hdr_data <= next_hdr_data;
      hdr_dir <= next_hdr_dir;
      // enable copy kept as its own flop so the pin enable is registered
      hdr_oe_b <= ~next_hdr_dir;
      shd_data <= next_shd_data;
      shd_dir <= next_shd_dir;
      shd_oe_b <= ~next_shd_dir;
      shd_rst <= next_shd_rst;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign rdata_o = rdata;
  assign rvalid_o = rvalid;
  assign red_lamp_outputs_o = lamp;
  // one bit per segment, straight from the stored word
  assign digit_zero_o = dig_low[0 +: MMPP_SEG_W];
  assign digit_one_o = dig_low[MMPP_SEG_W +: MMPP_SEG_W];
  assign digit_two_o = dig_low[2*MMPP_SEG_W +: MMPP_SEG_W];
  assign digit_three_o = dig_low[3*MMPP_SEG_W +: MMPP_SEG_W];
  assign digit_four_o = dig_high[0 +: MMPP_SEG_W];
  assign digit_five_o = dig_high[MMPP_SEG_W +: MMPP_SEG_W];
  // header bit n is header pin n in ascending order; spare pins not wired
  assign header_data_bits_o = hdr_data;
  assign header_data_bits_oe_b_o = hdr_oe_b;
  assign shield_user_signal_o = shd_data;
  assign shield_user_signal_oe_b_o = shd_oe_b;
  assign shield_reset_b_o = shd_rst;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic wr_lamp;
  logic rd_hdr;
  assign wr_lamp = wr_i && hit(addr_i, MMPP_LAMP_BASE);
  assign rd_hdr = rd_i && hit(addr_i, MMPP_HDR_BASE);

  lamp_write_a: assert property (wr_lamp |=> red_lamp_outputs_o == $past(wdata_i[9:0]))
    else $error("lamp outputs did not take written value");
  lamp_upper_a: assert property (rd_i && hit(addr_i, MMPP_LAMP_BASE) |=> rdata_o[31:10] == '0)
    else $error("lamp read shows bits above width");
  digit_back_a: assert property (wr_i && hit(addr_i, MMPP_DIG_HIGH_BASE)
      ##1 !(wr_i && hit(addr_i, MMPP_DIG_HIGH_BASE)) ##1 rd_i && !wr_i
      && hit(addr_i, MMPP_DIG_HIGH_BASE) |=> rdata_o == $past(wdata_i, 3))
    else $error("high digit register did not read back");
  segment_drive_a: assert property (wr_i && hit(addr_i, MMPP_DIG_LOW_BASE)
      |=> digit_three_o == $past(wdata_i[31:24]) && digit_zero_o == $past(wdata_i[7:0]))
    else $error("segments not driven from written bits");
  dir_enable_a: assert property (wr_i && hit(addr_i, MMPP_HDR_BASE + MMPP_DIR_OFS)
      |=> header_data_bits_oe_b_o == ~$past(wdata_i[HDR_W-1:0]))
    else $error("direction write did not set pin enables");
  input_view_a: assert property (rd_hdr && !wr_i |=> rdata_o[HDR_W-1:0] ==
      $past((~header_data_bits_oe_b_o & header_data_bits_o)
      | (header_data_bits_oe_b_o & hdr_pin)))
    else $error("header read mixes pins and data wrongly");
  button_read_a: assert property (rd_i && hit(addr_i, MMPP_BUTTON_BASE)
      |=> rdata_o == 32'($past(button_lvl)))
    else $error("button read does not show levels");
  lever_read_a: assert property (rd_i && hit(addr_i, MMPP_LEVER_BASE)
      |=> rdata_o == 32'($past(lever_lvl)))
    else $error("lever read does not show levels");
  spare_zero_a: assert property (rd_i && hit(addr_i, MMPP_SHIELD_BASE + MMPP_MASK_OFS)
      |=> rdata_o == '0)
    else $error("shield +8 word not zero");
  shrst_drive_a: assert property (wr_i && hit(addr_i, MMPP_SHRST_BASE)
      |=> shield_reset_b_o == $past(wdata_i[0]))
    else $error("shield reset not driven from data bit");
  read_answer_a: assert property (rd_i |=> rvalid_o ##1 !rvalid_o || $past(rd_i))
    else $error("read answer timing wrong");

  lamp_write_c: cover property (wr_lamp ##2 rd_i && hit(addr_i, MMPP_LAMP_BASE));
  shrst_release_c: cover property (wr_i && hit(addr_i, MMPP_SHRST_BASE) ##1 shield_reset_b_o);
  hdr_drive_c: cover property (header_data_bits_oe_b_o != '1 && rd_hdr);
  button_change_c: cover property (button_lvl != $past(button_lvl));
endmodule : mmpp_ports
`default_nettype wire

//--- core/README_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- dv/mmpp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmpp_cpu_model
(
  input wire logic mclk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic [31:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [31:0] wdata_o
);
  initial
  begin
    addr_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 32'h0;
  end
  // released lines flip so no stale address or data can pass for a live one
  task automatic write(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge mclk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : write
  task automatic read(input logic [31:0] a, output logic [31:0] d, output logic v);
    @(posedge mclk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge mclk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    v = rvalid_i;
  endtask : read
endmodule : mmpp_cpu_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import mmpp_pkg::*;
;
  logic mclk_i;
  logic rst_b_i;
  logic [31:0] addr, wdata, rdata, got;
  logic wr, rd, rvalid, v;
  logic [MMPP_LAMP_W-1:0] lamp;
  logic [MMPP_SEG_W-1:0] d0, d1, d2, d3, d4, d5;
  logic [MMPP_LEVER_W-1:0] levers;
  logic [MMPP_BUTTON_W-1:0] buttons;
  logic [31:0] hdr_ext, hdr_o, hdr_oe_b, hdr_pin, sh_ext, sh_o, sh_oe_b, sh_pin;
  logic sh_rst_b;
  int failures;
  int comparisons;
  logic [95:0] rows [0:13];
  // pin level: the port drives where its enable is low, the board elsewhere
  assign hdr_pin = (~hdr_oe_b & hdr_o) | (hdr_oe_b & hdr_ext);
  assign sh_pin = (~sh_oe_b & sh_o) | (sh_oe_b & sh_ext);
  mmpp_cpu_model cpu_u (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  mmpp_ports dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .red_lamp_outputs_o(lamp),
    .digit_zero_o(d0), .digit_one_o(d1), .digit_two_o(d2), .digit_three_o(d3),
    .digit_four_o(d4), .digit_five_o(d5), .slider_levers_i(levers),
    .pushbutton_inputs_i(buttons), .header_data_bits_i(hdr_pin), .header_data_bits_o(hdr_o),
    .header_data_bits_oe_b_o(hdr_oe_b), .shield_user_signal_i(sh_pin),
    .shield_user_signal_o(sh_o), .shield_user_signal_oe_b_o(sh_oe_b),
    .shield_reset_b_o(sh_rst_b));
  task automatic print_verdict();
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    cpu_u.read(a, got, v);
    chk("rvalid", 32'h1, {31'h0, v});
    chk("read data", exp, got);
  endtask : rd_chk
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial
  begin
    repeat (2000) @(posedge mclk_i);
    failures++;
    print_verdict();
  end
  initial
  begin
    failures = 0;
    comparisons = 0;
    rst_b_i = 1'b0;
    levers = 10'h2a5;
    buttons = 2'h2;
    hdr_ext = 32'hcafe0000;
    sh_ext = 32'h00001234;
    rows = '{{32'hff200000, 32'hffffffff, 32'h000003ff}, {32'hff200020, 32'h12345678,
      32'h12345678}, {32'hff200030, 32'h11223344, 32'h11223344}, {32'hff200040,
      32'hffffffff, 32'h000002a5}, {32'hff200050, 32'hffffffff, 32'h00000002},
      {32'hff200058, 32'hffffffff, 32'h0}, {32'hff200064, 32'h0000ffff, 32'h0000ffff},
      {32'hff200060, 32'h12345678, 32'hcafe5678}, {32'hff20006c, 32'hffffffff, 32'h0},
      {32'hff200104, 32'hffff0000, 32'hffff0000}, {32'hff200100, 32'h9abcbeef,
      32'h9abc1234}, {32'hff200110, 32'hfffffffe, 32'h0}, {32'hff200300, 32'hffffffff,
      32'h0}, {32'hff200108, 32'hffffffff, 32'h0}};
    repeat (3) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      cpu_u.write(rows[i][95:64], rows[i][63:32]);
      rd_chk(rows[i][95:64], rows[i][31:0]);
    end
    chk("lamp", 32'h3ff, {22'h0, lamp});
    chk("low digits", 32'h12345678, {d3, d2, d1, d0});
    chk("high digits", 32'h3344, {16'h0, d5, d4});
    chk("header enable", 32'hffff0000, hdr_oe_b);
    chk("header out", 32'h5678, {16'h0, hdr_o[15:0]});
    chk("shield enable", 32'h0000ffff, sh_oe_b);
    chk("shield out", 32'h9abc, {16'h0, sh_o[31:16]});
    chk("shield reset", 32'h0, {31'h0, sh_rst_b});
    cpu_u.write(32'hff200110, 32'h00000001);
    chk("shield reset", 32'h1, {31'h0, sh_rst_b});
    rd_chk(32'hff200110, 32'h1);
    sh_ext = 32'h00005678;
    repeat (5) @(posedge mclk_i);
    rd_chk(32'hff200100, 32'h9abc5678);
    // second reset in mid-run must clear every driven pin and direction
    @(posedge mclk_i);
    #1;
    rst_b_i = 1'b0;
    #2;
    chk("lamp reset", 32'h0, {22'h0, lamp});
    chk("digit reset", 32'h0, {d3, d2, d1, d0});
    chk("header enable reset", 32'hffffffff, hdr_oe_b);
    chk("shield enable reset", 32'hffffffff, sh_oe_b);
    chk("shield reset pin", 32'h0, {31'h0, sh_rst_b});
    repeat (3) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    rd_chk(32'hff200064, 32'h0);
    rd_chk(32'hff200030, 32'h0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
